// ### logic/ddc_channel_filter_ctrl.sv
/*
  Per-channel control bank of a downconverter channel: filter stage options,
  input select and format, overload monitor counter and double-buffered fine gain.
  Holds eight byte registers at offsets 0x18 to 0x1F, one of them read-only.
  Drives every control field as a registered output towards the datapath.
  Conditions the pin sample: top bit polarity and dual-stream filtering.
  Counts overloads or over-threshold words between monitor sync events.
  Keeps a written fine gain in a buffer until its sync event loads it.
  Filters, gain multipliers and converters themselves live elsewhere.
  Assumes a plain register port on clk, sync events and overflow flags
  arriving from logic on the same clock, and a sample bus with its flags arriving from pins.
  Assumes strobes one cycle wide, never a write and a read together.
  Assumes software keeps the test bit clear; nothing here enforces it.
  Assumes software enables the differential receivers elsewhere.
  Assumes pin words are stable around the edges that sample them.
  Read data stands only in the cycle after the read strobe.
  Unmapped offsets read zero and ignore writes.
  Reset is synchronous and clears the active gain to zero.
*/
`include "ddc_channel_filter_ctrl_consts.svh"

module ddc_channel_filter_ctrl #(
  parameter int SAMPLE_W = 16
) (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst,
  // Register port
  // Strobes one cycle wide, read data one cycle later
  input  wire logic [4:0]            reg_addr,
  input  wire logic [7:0]            reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output logic      [7:0]            reg_rdata,
  // Sync events, one bit per selectable sync source
  // Level tested each cycle, same clock as the bank
  input  wire logic [7:0]            sync_events,
  // Sample input from pins
  // Synchronised before any logic reads them
  input  wire logic [SAMPLE_W-1:0]   pin_sample,
  input  wire logic                  pin_sample_valid,
  input  wire logic                  pin_ab_flag,
  // Overflow flags from the datapath
  // One-cycle pulses, same clock, read directly
  input  wire logic                  first_stage_ovf,
  input  wire logic                  coarse_gain_ovf,
  input  wire logic                  second_stage_ovf,
  // Filter stage controls
  // Register bits, valid one edge after the write
  output logic                       first_stage_asym_en,
  output logic                       first_stage_q_delay,
  output logic                       first_stage_i_delay,
  output logic      [2:0]            coarse_gain_shift,
  output logic                       second_stage_asym_en,
  output logic                       second_stage_q_delay,
  output logic                       second_stage_i_delay,
  output logic      [7:0]            multichannel_mode,
  // Input routing
  // Port number and its receiver class
  output logic      [2:0]            input_port_sel,
  output logic      [1:0]            input_source,
  output logic      [1:0]            input_format,
  // Conditioned sample towards the datapath
  // Three clocks behind the pins
  output logic      [SAMPLE_W-1:0]   chan_sample,
  output logic                       chan_sample_valid,
  // Active fine gain, scale is value over 1024
  output logic      [13:0]           fine_gain_active
);

  // Storage split by owner: software bytes, monitor pair,
  // and the active gain that only a sync loads
  // Register storage
  logic [7:0]  mode_reg, mode_next;             // Multichannel mode control
  logic [7:0]  first_reg, first_next;           // First halfband control
  logic [7:0]  second_reg, second_next;         // Second halfband control
  logic [7:0]  input_reg, input_next;           // Input control
  logic [7:0]  mon_reg, mon_next;               // Monitor control
  logic [7:0]  gain_lo_reg, gain_lo_next;       // Buffered gain low byte
  logic [7:0]  gain_hi_reg, gain_hi_next;       // Buffered gain high byte
  // Hardware-updated monitor pair
  logic [7:0]  count_reg, count_next;           // Running monitor counter
  logic [7:0]  held_reg, held_next;             // Count of last sync period
  logic [13:0] gain_act_reg, gain_act_next;     // Active fine gain
  // Bus side
  logic [7:0]  rdata_reg, rdata_next;           // Read data
  // No gain sync field reaches this bank: select tied to
  // source zero, decode kept in place for a later hookup
  logic [7:0]  gsync_reg;                       // Gain sync field, held at zero inside this bank

  // Each pin bit passes two flops; the word and its
  // flags travel together so they stay aligned
  // Pin synchronisers
  logic [SAMPLE_W-1:0] smp_s1_reg, smp_s2_reg;  // Sample bits
  logic [1:0]          ctl_s1_reg, ctl_s2_reg;  // Valid and A/B flag
  logic [SAMPLE_W-1:0] smp_out_reg;             // Conditioned sample
  logic                smp_vld_reg;             // Conditioned valid

  // Shared by monitor and gain sync decode
  // Select one sync source by a three-bit field
  function automatic logic pick_sync(input logic [7:0] ev, input logic [2:0] sel);
    pick_sync = ev[sel];
  endfunction : pick_sync

  // One strobe per register; the read-only count has
  // none, so a write to its offset is dropped
  // Register write decode
  wire wr_mode   = reg_wr && (reg_addr == `OFS_MODE_CTRL);
  wire wr_first  = reg_wr && (reg_addr == `OFS_FIRST_HB);
  wire wr_second = reg_wr && (reg_addr == `OFS_SECOND_HB);
  wire wr_input  = reg_wr && (reg_addr == `OFS_INPUT_CTRL);
  wire wr_mon    = reg_wr && (reg_addr == `OFS_MON_CTRL);
  wire wr_glo    = reg_wr && (reg_addr == `OFS_GAIN_LOW);
  wire wr_ghi    = reg_wr && (reg_addr == `OFS_GAIN_HIGH);

  // Writes land at the next edge
  // Unused bits kept so readback matches the write
  // Every bit stored as written, unused ones included
  assign mode_next   = wr_mode   ? reg_wdata : mode_reg;
  assign first_next  = wr_first  ? reg_wdata : first_reg;
  assign second_next = wr_second ? reg_wdata : second_reg;
  assign input_next  = wr_input  ? reg_wdata : input_reg;
  assign mon_next    = wr_mon    ? reg_wdata : mon_reg;
  assign gain_lo_next = wr_glo   ? reg_wdata : gain_lo_reg;
  assign gain_hi_next = wr_ghi   ? reg_wdata : gain_hi_reg;

  // Zero outside a read, so banks may share a bus
  // by OR; the registered copy stands one cycle
  // Read-back mux, unmapped offsets read zero
  always_comb begin
    case (reg_addr)
      `OFS_MODE_CTRL:  rdata_next = mode_reg;
      `OFS_FIRST_HB:   rdata_next = first_reg;
      `OFS_SECOND_HB:  rdata_next = second_reg;
      `OFS_INPUT_CTRL: rdata_next = input_reg;
      `OFS_MON_CTRL:   rdata_next = mon_reg;
      `OFS_MON_COUNT:  rdata_next = held_reg;
      `OFS_GAIN_LOW:   rdata_next = gain_lo_reg;
      `OFS_GAIN_HIGH:  rdata_next = gain_hi_reg;
      default:         rdata_next = 8'h00;
    endcase
    // Idle cycles drive zero
    if (!reg_rd) begin
      rdata_next = 8'h00;
    end
  end

  // Slices taken once so every consumer sees one decode
  // Fields change only on a register write
  // Control fields
  wire [2:0] mon_sync_sel = mon_reg[`POS_MON_SYNC +: 3];
  wire [1:0] thresh_code  = mon_reg[`POS_THRESH +: 2];
  wire       mon_mode     = mon_reg[`BIT_MON_MODE];
  wire [1:0] ovf_sel      = second_reg[`POS_OVF_SEL +: 2];
  wire [2:0] in_sel       = input_reg[`POS_IN_SEL +: 3];
  wire [1:0] in_fmt       = input_reg[`POS_IN_FMT +: 2];
  wire       pick_ab      = input_reg[`BIT_PICK];
  wire       top_invert   = input_reg[`BIT_TOP_INVERT];
  wire [2:0] gain_sync_sel = gsync_reg[`POS_GAIN_SYNC +: 3];

  // Monitor and gain may follow different events; a held
  // event acts on every cycle it stands
  // Sync events
  wire mon_sync  = pick_sync(sync_events, mon_sync_sel);
  wire gain_sync = pick_sync(sync_events, gain_sync_sel);

  // No code left undefined
  // Overflow source: 0 first stage, 1 coarse, 2 and 3 second stage
  wire ovf_flag = (ovf_sel == 2'h0) ? first_stage_ovf :
                  (ovf_sel == 2'h1) ? coarse_gain_ovf : second_stage_ovf;

  // Ports 0 to 3 single, 4 and 5 differential, 6 and 7
  // internal diagnostic: the class the receivers need
  // Input source class from the select field
  wire [1:0] src_class = in_sel[2] ? (in_sel[1] ? 2'(ddc_channel_filter_ctrl_pkg::SRC_DIAG)
                                                : 2'(ddc_channel_filter_ctrl_pkg::SRC_DIFF))
                                   : 2'(ddc_channel_filter_ctrl_pkg::SRC_SINGLE);

  // Flipping one bit maps offset binary onto two's
  // complement without an adder
  // Sample conditioning: top bit inverted for offset binary
  wire [SAMPLE_W-1:0] smp_fixed = {smp_s2_reg[SAMPLE_W-1] ^ top_invert,
                                   smp_s2_reg[SAMPLE_W-2:0]};
  // A word of the other stream leaves valid low
  // Dual format accepts only samples whose flag matches the pick bit
  wire is_dual  = (in_fmt == 2'(ddc_channel_filter_ctrl_pkg::FMT_DUAL_12EXP));
  wire accept   = ctl_s2_reg[0] && (!is_dual || (ctl_s2_reg[1] == pick_ab));

  // Negation cannot overflow: the most negative word
  // maps to 1024, which still fits eleven bits
  // Magnitude of top 11 bits against quarter-scale thresholds
  wire [10:0] top11   = smp_fixed[SAMPLE_W-1 -: 11];
  wire [10:0] mag11   = top11[10] ? 11'(~top11 + 11'h001) : top11;
  wire [10:0] thresh  = 11'(({9'h000, thresh_code} + 11'h001) << 8);
  wire        over_th = accept && (mag11 >= thresh);

  // Threshold path counts only accepted words
  // Monitor source by mode bit
  wire mon_hit = mon_mode ? ovf_flag : over_th;

  // A hit in the sync cycle opens the new period, so
  // no event is lost across the boundary
  // Counter: clear on sync, else saturating increment
  always_comb begin
    count_next = count_reg;
    held_next  = held_reg;
    if (mon_sync) begin
      held_next  = count_reg;
      count_next = mon_hit ? 8'h01 : 8'h00;
    // Otherwise count up unless already at the top
    end else if (mon_hit && count_reg != `MON_COUNT_MAX) begin
      count_next = 8'(count_reg + 8'h01);
    end
  end

  // Bytes may be written in any order; the datapath sees
  // one fourteen-bit step, never a half-written value
  // Active gain loads from the buffer only on its sync
  assign gain_act_next = gain_sync ? {gain_hi_reg[5:0], gain_lo_reg} : gain_act_reg;

  // Software-visible bytes; write and readback may abut
  // Register bank
  always_ff @(posedge clk) begin
    if (rst) begin
      mode_reg    <= `RST_MODE_CTRL;
      first_reg   <= `RST_FIRST_HB;
      second_reg  <= `RST_SECOND_HB;
      input_reg   <= `RST_INPUT_CTRL;
      mon_reg     <= `RST_MON_CTRL;
      gain_lo_reg <= `RST_GAIN_LOW;
      gain_hi_reg <= `RST_GAIN_HIGH;
    end else begin
      mode_reg    <= mode_next;
      first_reg   <= first_next;
      second_reg  <= second_next;
      input_reg   <= input_next;
      mon_reg     <= mon_next;
      gain_lo_reg <= gain_lo_next;
      gain_hi_reg <= gain_hi_next;
    end
  end

  // Hardware-owned state; reset clears both counts and
  // the active gain, so the channel starts at zero gain
  // until the first gain sync
  // Monitor, gain and read data
  always_ff @(posedge clk) begin
    if (rst) begin
      count_reg    <= 8'h00;
      held_reg     <= 8'h00;
      gain_act_reg <= 14'h0000;
      rdata_reg    <= 8'h00;
      gsync_reg    <= 8'h00;
    end else begin
      count_reg    <= count_next;
      held_reg     <= held_next;
      gain_act_reg <= gain_act_next;
      rdata_reg    <= rdata_next;
      gsync_reg    <= 8'h00;
    end
  end

  // Only the second stage reads the first
  // Multi-bit word relies on stable pins at the edge
  // Two-stage pin synchroniser
  always_ff @(posedge clk) begin
    if (rst) begin
      smp_s1_reg <= '0;
      smp_s2_reg <= '0;
      ctl_s1_reg <= 2'h0;
      ctl_s2_reg <= 2'h0;
    end else begin
      smp_s1_reg <= pin_sample;
      smp_s2_reg <= smp_s1_reg;
      ctl_s1_reg <= {pin_ab_flag, pin_sample_valid};
      ctl_s2_reg <= ctl_s1_reg;
    end
  end

  // One more flop so every output comes from a register
  // Pin to output latency is three clocks
  // Conditioned sample stage
  always_ff @(posedge clk) begin
    if (rst) begin
      smp_out_reg <= '0;
      smp_vld_reg <= 1'b0;
    end else begin
      smp_out_reg <= smp_fixed;
      smp_vld_reg <= accept;
    end
  end

  // Control fields wired from register bytes, which are
  // flops, so they change one edge after the write
  // Outputs straight from flip-flops
  assign reg_rdata            = rdata_reg;
  assign first_stage_asym_en  = first_reg[`BIT_ASYM];
  assign first_stage_q_delay  = first_reg[`BIT_Q_DELAY];
  assign first_stage_i_delay  = first_reg[`BIT_I_DELAY];
  assign coarse_gain_shift    = first_reg[`POS_COARSE +: 3];
  assign second_stage_asym_en = second_reg[`BIT_ASYM];
  assign second_stage_q_delay = second_reg[`BIT_Q_DELAY];
  assign second_stage_i_delay = second_reg[`BIT_I_DELAY];
  assign multichannel_mode    = mode_reg;
  assign input_port_sel       = input_reg[`POS_IN_SEL +: 3];
  assign input_format         = input_reg[`POS_IN_FMT +: 2];
  assign chan_sample          = smp_out_reg;
  assign chan_sample_valid    = smp_vld_reg;
  assign fine_gain_active     = gain_act_reg;

  // Follows the select by one edge, one edge behind input_port_sel and input_format
  // Source class registered for a flop-driven output
  logic [1:0] src_reg;
  always_ff @(posedge clk) begin
    if (rst) begin
      src_reg <= 2'h0;
    end else begin
      src_reg <= src_class;
    end
  end
  assign input_source = src_reg;

endmodule : ddc_channel_filter_ctrl

// ### logic/ddc_channel_filter_ctrl_consts.svh
/*
  Offsets, field positions and reset values of the channel filter control bank.
  Assumes inclusion by bare name from the design file.
*/
`ifndef DDC_CHANNEL_FILTER_CTRL_CONSTS_SVH
`define DDC_CHANNEL_FILTER_CTRL_CONSTS_SVH
// Register offsets
`define OFS_MODE_CTRL     5'h18
`define OFS_FIRST_HB      5'h19
`define OFS_SECOND_HB     5'h1A
`define OFS_INPUT_CTRL    5'h1B
`define OFS_MON_CTRL      5'h1C
`define OFS_MON_COUNT     5'h1D
`define OFS_GAIN_LOW      5'h1E
`define OFS_GAIN_HIGH     5'h1F
// Reset values
`define RST_MODE_CTRL     8'h00
`define RST_FIRST_HB      8'h00
`define RST_SECOND_HB     8'h00
`define RST_INPUT_CTRL    8'h00
`define RST_MON_CTRL      8'h1D
`define RST_GAIN_LOW      8'h00
`define RST_GAIN_HIGH     8'h00
// Field positions
`define BIT_ASYM          0
`define BIT_Q_DELAY       1
`define BIT_I_DELAY       2
`define POS_COARSE        4
`define BIT_TEST          7
`define POS_OVF_SEL       3
`define POS_IN_SEL        0
`define BIT_PICK          3
`define POS_IN_FMT        4
`define BIT_TOP_INVERT    7
`define POS_MON_SYNC      0
`define POS_THRESH        3
`define BIT_MON_MODE      5
`define POS_GAIN_SYNC     4
// Counter limit
`define MON_COUNT_MAX     8'hFF
`endif

// ### logic/ddc_channel_filter_ctrl_pkg.sv
/*
  Types of the channel filter control bank.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package ddc_channel_filter_ctrl_pkg;
  // Input sample format
  typedef enum logic [1:0] {
    FMT_14BIT, FMT_16BIT, FMT_12EXP, FMT_DUAL_12EXP
  } in_format_type;
  // Routed input source
  typedef enum logic [1:0] {
    SRC_SINGLE, SRC_DIFF, SRC_DIAG
  } in_source_type;
endpackage : ddc_channel_filter_ctrl_pkg

// ### sim/adc_stream_model.sv
/*
  Converter-side model driving the channel's pin sample bus.
  Assumes the bench clock; idle bus inverts its word on every edge, alternating between the last word and its inverse.
*/
module adc_stream_model #(
  parameter int SAMPLE_W = 16
) (
  input wire logic            clk,
  input wire logic            run,               // Streams while high
  output logic [SAMPLE_W-1:0] pin_sample,
  output logic                pin_sample_valid,
  output logic                pin_ab_flag        // Interleaves two streams
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {pin_sample, pin_sample_valid, pin_ab_flag} = '0;
  // New word each edge while running, otherwise word inverted each edge with valid low
  always @(posedge clk) begin
    if (run) begin
      pin_sample       <= SAMPLE_W'($urandom);
      pin_sample_valid <= ($urandom_range(3) != 0);
      pin_ab_flag      <= ~pin_ab_flag;
    end else begin
      pin_sample       <= ~pin_sample;
      pin_sample_valid <= 1'b0;
    end
  end
endmodule : adc_stream_model

// ### sim/ddc_channel_filter_ctrl_assertions.sv
/*
  Port-level assertions of the channel filter control bank.
  Assumes one clock, synchronous active-high reset, bound to the design top.
*/
`include "ddc_channel_filter_ctrl_consts.svh"
module ddc_channel_filter_ctrl_assertions #(
  parameter int SAMPLE_W = 16
) (
  // Clock, reset and register port
  input wire logic                clk,
  input wire logic                rst,
  input wire logic                reg_wr,
  input wire logic                reg_rd,
  input wire logic [4:0]          reg_addr,
  input wire logic [7:0]          reg_wdata,
  input wire logic [7:0]          reg_rdata,
  input wire logic [7:0]          sync_events,
  // Sample path
  input wire logic [SAMPLE_W-1:0] pin_sample,
  input wire logic [SAMPLE_W-1:0] chan_sample,
  input wire logic                pin_sample_valid,
  input wire logic                pin_ab_flag,
  input wire logic                chan_sample_valid,
  // Controls
  input wire logic                first_stage_asym_en,
  input wire logic                first_stage_q_delay,
  input wire logic                first_stage_i_delay,
  input wire logic [2:0]          coarse_gain_shift,
  input wire logic [2:0]          input_port_sel,
  input wire logic [1:0]          input_source,
  input wire logic [1:0]          input_format,
  input wire logic [13:0]         fine_gain_active
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic [13:0] gain_shadow_reg;  // Written gain, not yet active
  logic [2:0]  cfg_age_reg;      // Cycles since input control write
  logic        invert_reg;       // Written top bit invert
  logic        pick_reg;         // Written stream pick
  // Shadow of software writes
  always_ff @(posedge clk) begin
    if (rst) begin
      gain_shadow_reg <= 14'h0000;
      cfg_age_reg     <= 3'h0;
      invert_reg      <= 1'b0;
      pick_reg        <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == `OFS_GAIN_LOW) gain_shadow_reg[7:0] <= reg_wdata;
      if (reg_wr && reg_addr == `OFS_GAIN_HIGH) gain_shadow_reg[13:8] <= reg_wdata[5:0];
      if (reg_wr && reg_addr == `OFS_INPUT_CTRL) begin
        cfg_age_reg <= 3'h0;
        invert_reg  <= reg_wdata[7];
        pick_reg    <= reg_wdata[3];
      end else if (cfg_age_reg != 3'h7) begin
        cfg_age_reg <= cfg_age_reg + 3'h1;
      end
    end
  end
  sequence wr_at(logic [4:0] a);
    reg_wr && reg_addr == a;
  endsequence
  sequence wr_then_rd;
    reg_wr && reg_addr[4:3] == 2'b11 && reg_addr != `OFS_MON_COUNT ##1 reg_rd && $stable(reg_addr);
  endsequence
  chk_rdata_idle:
    assert property (!reg_rd |=> reg_rdata == 8'h00) else $error("read data outside a read");
  chk_read_back:
    assert property (wr_then_rd |=> reg_rdata == $past(reg_wdata, 2)) else $error("readback");
  chk_first_stage:
    assert property (wr_at(`OFS_FIRST_HB) |=> {coarse_gain_shift, first_stage_i_delay,
      first_stage_q_delay, first_stage_asym_en} == {$past(reg_wdata[6:4]), $past(reg_wdata[2:0])})
    else $error("first stage controls");
  chk_input_fields:
    assert property (wr_at(`OFS_INPUT_CTRL) |=> input_port_sel == $past(reg_wdata[2:0])
      && input_format == $past(reg_wdata[5:4])) else $error("input fields");
  chk_source_map:
    assert property ($stable(input_port_sel) |-> input_source == (!input_port_sel[2] ? 2'h0
      : (input_port_sel[1] ? 2'h2 : 2'h1))) else $error("input source");
  chk_gain_hold:
    assert property (!sync_events[0] |=> $stable(fine_gain_active)) else $error("gain moved");
  chk_gain_load:
    assert property (sync_events[0] && !reg_wr |=> fine_gain_active == $past(gain_shadow_reg))
    else $error("gain transfer");
  chk_sample_pick:
    assert property (cfg_age_reg > 3'h3 |-> chan_sample_valid == ($past(pin_sample_valid, 3)
      && (input_format != 2'h3 || $past(pin_ab_flag, 3) == pick_reg))) else $error("valid");
  chk_sample_sign:
    assert property (cfg_age_reg > 3'h3 && chan_sample_valid |-> chan_sample
      == ($past(pin_sample, 3) ^ {invert_reg, {(SAMPLE_W-1){1'b0}}})) else $error("sample");
endmodule : ddc_channel_filter_ctrl_assertions

bind ddc_channel_filter_ctrl ddc_channel_filter_ctrl_assertions #(.SAMPLE_W(SAMPLE_W)) chk (
  .clk, .rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .sync_events, .pin_sample,
  .chan_sample, .pin_sample_valid, .pin_ab_flag, .chan_sample_valid, .first_stage_asym_en,
  .first_stage_q_delay, .first_stage_i_delay, .coarse_gain_shift, .input_port_sel,
  .input_source, .input_format, .fine_gain_active);

// ### sim/ddc_channel_filter_ctrl_tb_top.sv
/*
  Self-checking bench of the channel filter control bank.
  Assumes the design, its header, checker and converter model compile first.
*/
`include "ddc_channel_filter_ctrl_consts.svh"
module ddc_channel_filter_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst, reg_wr, reg_rd, run, counting;
  logic [4:0]  reg_addr;
  logic [7:0]  reg_wdata, reg_rdata, sync_events, q, multichannel_mode, m [8];
  logic [15:0] pin_sample, chan_sample;
  logic        pin_sample_valid, pin_ab_flag, chan_sample_valid;
  logic        first_stage_ovf, coarse_gain_ovf, second_stage_ovf;
  logic        first_stage_asym_en, first_stage_q_delay, first_stage_i_delay;
  logic        second_stage_asym_en, second_stage_q_delay, second_stage_i_delay;
  logic [2:0]  coarse_gain_shift, input_port_sel;
  logic [1:0]  input_source, input_format, thr_code;
  logic [13:0] fine_gain_active, gain_prev;
  int          miscompares, checks_done, cycles, hits;
  wire [2:0]   stage2 = {second_stage_i_delay, second_stage_q_delay, second_stage_asym_en};
  ddc_channel_filter_ctrl #(.SAMPLE_W(16)) dut (.clk, .rst, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .sync_events, .pin_sample, .pin_sample_valid, .pin_ab_flag,
    .first_stage_ovf, .coarse_gain_ovf, .second_stage_ovf, .first_stage_asym_en,
    .first_stage_q_delay, .first_stage_i_delay, .coarse_gain_shift, .second_stage_asym_en,
    .second_stage_q_delay, .second_stage_i_delay, .multichannel_mode, .input_port_sel,
    .input_source, .input_format, .chan_sample, .chan_sample_valid, .fine_gain_active);
  adc_stream_model #(.SAMPLE_W(16)) adc (.clk, .run, .pin_sample, .pin_sample_valid,
    .pin_ab_flag);
  initial clk = 1'b0;
  always #2.5 clk = ~clk;
  // Hang guard and reference count of over-threshold words
  always @(posedge clk) begin
    cycles++;
    if (counting && pin_sample_valid && over(pin_sample, thr_code)) hits++;
    if (cycles == 20000) begin
      miscompares++;
      wrap_up();
    end
  end
  function automatic bit over(logic [15:0] s, logic [1:0] c);
    int mag;
    mag = int'(signed'(s[15:5]));
    return (mag < 0 ? -mag : mag) >= (int'(c) + 1) * 256;
  endfunction : over
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic get(input logic [4:0] a);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 q = reg_rdata;
    @(posedge clk);
  endtask : get
  task automatic put(input logic [4:0] a, input logic [7:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    get(a);
    if (a != `OFS_MON_COUNT) check("readback", q, d);
  endtask : put
  task automatic pulse(input logic [7:0] s);
    sync_events <= s;
    @(posedge clk);
    sync_events <= 8'h00;
    @(posedge clk);
  endtask : pulse
  task automatic wrap_up();
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : wrap_up
  initial begin
    void'($urandom(75));
    {rst, reg_wr, reg_rd, run, counting, first_stage_ovf, coarse_gain_ovf} = 7'h40;
    {second_stage_ovf, reg_addr, reg_wdata, sync_events, thr_code, gain_prev} = '0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    // Reset values, read-only count, unmapped offset
    for (int i = 0; i < 8; i++) begin
      get(5'h18 + 5'(i));
      check("reset", q, i == 4 ? 8'h1D : 8'h00);
    end
    put(`OFS_MON_COUNT, 8'hA5);
    check("read-only count", q, 8'h00);
    get(5'h05);
    check("unmapped", q, 8'h00);
    $display("test reset_map done");
    // Random controls over every input select; gain waits for its sync
    for (int it = 0; it < 16; it++) begin
      for (int i = 0; i < 8; i++) m[i] = 8'($urandom);
      m[1][7] = 1'b0;
      m[3][2:0] = 3'(it);
      for (int i = 0; i < 8; i++) if (i != 5) put(5'h18 + 5'(i), m[i]);
      check("mode", multichannel_mode, m[0]);
      check("stage2", stage2, m[2][2:0]);
      check("format", input_format, m[3][5:4]);
      check("gain held", fine_gain_active, gain_prev);
      pulse(8'h02);
      check("other sync", fine_gain_active, gain_prev);
      pulse(8'h01);
      gain_prev = {m[7][5:0], m[6]};
      check("gain", fine_gain_active, gain_prev);
    end
    $display("test controls done");
    // Stream through each format, polarity and pick
    for (int k = 0; k < 8; k++) begin
      put(`OFS_INPUT_CTRL, {k[0], 1'b0, 2'(k >> 1), k[2] ^ k[0], 3'h0});
      run <= 1'b1;
      repeat (40) @(posedge clk);
      run <= 1'b0;
    end
    $display("test stream done");
    // Threshold counting per code, saturating on the first
    put(`OFS_INPUT_CTRL, 8'h10);
    for (int c = 0; c < 4; c++) begin
      thr_code <= 2'(c);
      put(`OFS_MON_CTRL, {3'h0, 2'(c), 3'(c + 1)});
      pulse(8'(8'h01 << (c + 1)));
      hits = 0;
      counting <= 1'b1;
      run <= 1'b1;
      repeat (c == 0 ? 700 : 60) @(posedge clk);
      run <= 1'b0;
      repeat (6) @(posedge clk);
      counting <= 1'b0;
      pulse(8'(8'h01 << (c + 1)));
      get(`OFS_MON_COUNT);
      check("peak count", q, hits > 255 ? 8'hFF : 8'(hits));
    end
    $display("test threshold done");
    // Overflow source select, all four codes
    for (int s = 0; s < 4; s++) begin
      put(`OFS_SECOND_HB, {3'h0, 2'(s), 3'h0});
      put(`OFS_MON_CTRL, 8'h21);
      pulse(8'h02);
      for (int j = 0; j < 7; j++) begin
        {first_stage_ovf, coarse_gain_ovf, second_stage_ovf} <= {j < 3, j < 5, 1'b1};
        @(posedge clk);
        {first_stage_ovf, coarse_gain_ovf, second_stage_ovf} <= 3'h0;
        @(posedge clk);
      end
      repeat (4) @(posedge clk);
      pulse(8'h02);
      get(`OFS_MON_COUNT);
      check("overflow count", q, s == 0 ? 8'h03 : (s == 1 ? 8'h05 : 8'h07));
    end
    $display("test overflow done");
    // Mid-run reset brings every register back
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      get(5'h18 + 5'(i));
      check("reset again", q, i == 4 ? 8'h1D : 8'h00);
    end
    check("gain cleared", fine_gain_active, 14'h0000);
    $display("test mid reset done");
    wrap_up();
  end
endmodule : ddc_channel_filter_ctrl_tb_top
